/* File: core/clock_and_power_mode_control.sv */
`timescale 1ns/1ps
`include "clk_pwr_ctrl_consts.svh"

//Overview of operation
// - After reset, processor clock comes from internal RC oscillator until software changes.
// - Software picks RC, main crystal or real-time oscillator as PLL reference.
// - PLL reference passes a pre-divider programmable from 1 to 256.
// - PLL feedback divider on oscillator output programmable from 1 to 32768.
// - PLL disabled and bypassed after reset and on power-down; software re-enables.
// - Processor clock equals reference unless PLL enabled and connected.
// - Every peripheral has its own software-set clock divider.
// - Software can stop any single peripheral clock.
// - Four power-reduction modes: idle, sleep, power-down, deep power-down.
// - Power-up and power-down or deep wake resume on internal RC oscillator.
// - Wake-up timer holds execution from main oscillator until it is stable.
// - Idle stops only CPU execution; interrupt or reset resumes.
// - Sleep stops oscillator and all internal clocks, state preserved.
// - Sleep gates RC output but keeps it powered; real-time oscillator runs.
// - Entering sleep disables and disconnects the PLL.
// - Entering sleep clears CPU and USB clock dividers to zero.
// - Sleep ends on reset or clockless interrupt, then operation resumes.
// - Sleep wake holds 4 cycles of the RC or real-time source, or 4096 main oscillator cycles.
// - Power-down also stops RC; wake waits start-up time plus 4 cycles.
// - Deep power-down removes core power; leaving it acts as full reset.
module clock_and_power_mode_control
  import clk_pwr_ctrl_pkg::*;
#(
  parameter int RC_START_CYC = `RC_START_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire osc_ticks_s ticks,
  input wire logic pllLock,
  input wire logic wakeIrq,
  output pll_drive_s pllDrive,
  output logic cpuClkEn,
  output logic usbClkEn,
  output logic [3:0] periphClkEn,
  output logic cpuRun,
  output logic rcOutEn,
  output logic rcPowerOn,
  output logic mainOscOn,
  output logic coreSupplyOn,
  output logic chipResetReq
);

  typedef struct packed {
    clk_src_e src;
    clk_src_e srcBefore;
    logic [7:0] preDiv;
    logic [14:0] mult;
    logic pllEn;
    logic pllConn;
    logic [7:0] cpuDiv;
    logic [7:0] usbDiv;
    logic [3:0] gate;
    logic [31:0] pDiv;
    pwr_mode_e mode;
    logic [12:0] holdCnt;
    logic [15:0] rcCnt;
    logic [12:0] mainCnt;
    logic mainReady;
    logic mainOn;
    logic [7:0] preCnt;
    logic [14:0] fbCnt;
    logic [7:0] cpuCnt;
    logic [7:0] usbCnt;
    logic [31:0] pCnt;
    logic refTick;
    logic fbTick;
    logic cpuTick;
    logic usbTick;
    logic [3:0] pTick;
    logic rstReq;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
  } state_s;

  localparam state_s RESET_STATE = '{
    src: SRC_RC,
    srcBefore: SRC_RC,
    preDiv: `RST_PRE_DIV,
    mult: `RST_MULT,
    pllEn: 1'b0,
    pllConn: 1'b0,
    cpuDiv: `RST_DIV,
    usbDiv: `RST_DIV,
    gate: `RST_GATE,
    pDiv: 32'h00000000,
    mode: PM_RUN,
    holdCnt: 13'h0000,
    rcCnt: 16'h0000,
    mainCnt: 13'h0000,
    mainReady: 1'b0,
    mainOn: 1'b1,
    preCnt: 8'h00,
    fbCnt: 15'h0000,
    cpuCnt: 8'h00,
    usbCnt: 8'h00,
    pCnt: 32'h00000000,
    refTick: 1'b0,
    fbTick: 1'b0,
    cpuTick: 1'b0,
    usbTick: 1'b0,
    pTick: 4'h0,
    rstReq: 1'b0,
    wrPend: 1'b0,
    wrAddr: 8'h00,
    rdata: 32'h00000000
  };

  state_s s;
  state_s next_s;
  logic srcTick;
  logic baseTick;
  logic clocksOn;
  logic execOk;
  logic [12:0] holdTarget;

  // Register read view; unmapped offsets read zero
  function automatic logic [31:0] readMux(input state_s st, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      `OFS_CLK_SRC: d[1:0] = st.src;
      `OFS_PLL_CFG: begin
        d[`POS_PRE_DIV +: 8] = st.preDiv;
        d[`POS_MULT +: 15] = st.mult;
      end
      `OFS_PLL_CTL: begin
        d[`POS_PLL_EN] = st.pllEn;
        d[`POS_PLL_CONN] = st.pllConn;
      end
      `OFS_PLL_STAT: begin
        d[`POS_PLL_EN] = st.pllEn;
        d[`POS_PLL_CONN] = st.pllConn;
        d[`POS_PLL_LOCK] = pllLock;
        d[`POS_MAIN_READY] = st.mainReady;
      end
      `OFS_CLK_DIV: begin
        d[`POS_CPU_DIV +: 8] = st.cpuDiv;
        d[`POS_USB_DIV +: 8] = st.usbDiv;
      end
      `OFS_PERIPH_GATE: d[3:0] = st.gate;
      `OFS_PERIPH_DIV: d = st.pDiv;
      `OFS_PWR_MODE: d[2:0] = st.mode;
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction

  // Selected source and the clock that feeds the dividers
  always_comb begin
    unique case (s.src)
      SRC_RC: srcTick = ticks.rc;
      SRC_MAIN: srcTick = ticks.main;
      default: srcTick = ticks.rtc;
    endcase
    baseTick = (s.pllEn && s.pllConn) ? ticks.currentControlledOscillator : srcTick;
    clocksOn = (s.mode == PM_RUN) || (s.mode == PM_IDLE);
    execOk = !((s.src == SRC_MAIN) && !s.mainReady);
    holdTarget = (s.srcBefore == SRC_MAIN) ? `HOLD_MAIN_TICKS : `HOLD_RC_TICKS;
  end

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    next_s.refTick = 1'b0;
    next_s.fbTick = 1'b0;
    next_s.cpuTick = 1'b0;
    next_s.usbTick = 1'b0;
    next_s.pTick = 4'h0;
    next_s.rstReq = 1'b0;

    // Address phase; zero-wait, so read data is fetched here
    next_s.wrPend = hsel && htrans[1] && hwrite && hready;
    next_s.wrAddr = haddr[7:0];
    if (hsel && htrans[1] && !hwrite && hready) begin
      next_s.rdata = readMux(s, haddr[7:0]);
    end

    // Data phase of a write
    if (s.wrPend) begin
      case (s.wrAddr)
        `OFS_CLK_SRC: begin
          // Code 3 is not a source, so it is ignored
          if (hwdata[1:0] != 2'b11) begin
            next_s.src = clk_src_e'(hwdata[1:0]);
          end
        end
        `OFS_PLL_CFG: begin
          next_s.preDiv = hwdata[`POS_PRE_DIV +: 8];
          next_s.mult = hwdata[`POS_MULT +: 15];
        end
        `OFS_PLL_CTL: begin
          next_s.pllEn = hwdata[`POS_PLL_EN];
          // Connect only sticks while the PLL is enabled
          next_s.pllConn = hwdata[`POS_PLL_CONN] && hwdata[`POS_PLL_EN];
        end
        `OFS_CLK_DIV: begin
          next_s.cpuDiv = hwdata[`POS_CPU_DIV +: 8];
          next_s.usbDiv = hwdata[`POS_USB_DIV +: 8];
        end
        `OFS_PERIPH_GATE: next_s.gate = hwdata[3:0];
        `OFS_PERIPH_DIV: next_s.pDiv = hwdata;
        `OFS_PWR_MODE: begin
          if (s.mode == PM_RUN) begin
            case (hwdata[2:0])
              `CMD_IDLE: next_s.mode = PM_IDLE;
              `CMD_SLEEP, `CMD_PDOWN: begin
                next_s.mode = (hwdata[2:0] == `CMD_SLEEP) ? PM_SLEEP : PM_PDOWN;
                next_s.srcBefore = s.src;
                next_s.pllEn = 1'b0;
                next_s.pllConn = 1'b0;
                next_s.cpuDiv = 8'h00;
                next_s.usbDiv = 8'h00;
                next_s.mainOn = 1'b0;
                next_s.mainCnt = 13'h0000;
                next_s.mainReady = 1'b0;
              end
              `CMD_DEEP: begin
                next_s.mode = PM_DEEP;
                next_s.pllEn = 1'b0;
                next_s.pllConn = 1'b0;
                next_s.mainOn = 1'b0;
              end
              default: next_s.mode = s.mode;
            endcase
          end
        end
        default: next_s.mode = next_s.mode;
      endcase
    end

    // Wake-up timer for the main oscillator after any start
    if (s.mainOn && !s.mainReady && ticks.main) begin
      next_s.mainCnt = s.mainCnt + 13'h0001;
      if (s.mainCnt == `HOLD_MAIN_TICKS - 13'h0001) begin
        next_s.mainReady = 1'b1;
      end
    end

    // Power mode sequencing
    unique case (s.mode)
      PM_RUN: next_s.mode = next_s.mode;
      PM_IDLE: begin
        if (wakeIrq) begin
          next_s.mode = PM_RUN;
        end
      end
      PM_SLEEP: begin
        if (wakeIrq) begin
          next_s.mode = PM_HOLD;
          next_s.holdCnt = 13'h0000;
          next_s.mainOn = 1'b1;
        end
      end
      PM_PDOWN: begin
        if (wakeIrq) begin
          next_s.mode = PM_RCSTART;
          next_s.rcCnt = 16'h0000;
          next_s.src = SRC_RC;
          next_s.srcBefore = SRC_RC;
          next_s.mainOn = 1'b1;
        end
      end
      PM_RCSTART: begin
        // RC start-up time counted on the system clock
        if (s.rcCnt == 16'(RC_START_CYC - 1)) begin
          next_s.mode = PM_HOLD;
          next_s.holdCnt = 13'h0000;
        end else begin
          next_s.rcCnt = s.rcCnt + 16'h0001;
        end
      end
      PM_HOLD: begin
        if (srcTick) begin
          next_s.holdCnt = s.holdCnt + 13'h0001;
          if (s.holdCnt == holdTarget - 13'h0001) begin
            next_s.mode = PM_RUN;
          end
        end
      end
      PM_DEEP: begin
        // Leaving deep power-down restarts as from a full reset
        if (wakeIrq) begin
          next_s = RESET_STATE;
          next_s.rstReq = 1'b1;
        end
      end
      default: next_s.mode = PM_RUN;
    endcase

    // PLL reference pre-divider, ratio preDiv+1
    if (s.pllEn && srcTick) begin
      if (s.preCnt >= s.preDiv) begin
        next_s.preCnt = 8'h00;
        next_s.refTick = 1'b1;
      end else begin
        next_s.preCnt = s.preCnt + 8'h01;
      end
    end

    // Feedback divider on the oscillator output, ratio mult+1
    if (s.pllEn && ticks.currentControlledOscillator) begin
      if (s.fbCnt >= s.mult) begin
        next_s.fbCnt = 15'h0000;
        next_s.fbTick = 1'b1;
      end else begin
        next_s.fbCnt = s.fbCnt + 15'h0001;
      end
    end

    // Processor clock divider; whole pulses only, never runts
    if (clocksOn && baseTick) begin
      if (s.cpuCnt >= s.cpuDiv) begin
        next_s.cpuCnt = 8'h00;
        next_s.cpuTick = (s.mode == PM_RUN) && execOk;
      end else begin
        next_s.cpuCnt = s.cpuCnt + 8'h01;
      end
    end

    // USB clock divider from the PLL oscillator
    if (clocksOn && s.pllEn && ticks.currentControlledOscillator) begin
      if (s.usbCnt >= s.usbDiv) begin
        next_s.usbCnt = 8'h00;
        next_s.usbTick = 1'b1;
      end else begin
        next_s.usbCnt = s.usbCnt + 8'h01;
      end
    end

    // Per-peripheral divider and gate
    for (int i = 0; i < 4; i++) begin
      if (clocksOn && baseTick && s.gate[i]) begin
        if (s.pCnt[i*8 +: 8] >= s.pDiv[i*8 +: 8]) begin
          next_s.pCnt[i*8 +: 8] = 8'h00;
          next_s.pTick[i] = 1'b1;
        end else begin
          next_s.pCnt[i*8 +: 8] = s.pCnt[i*8 +: 8] + 8'h01;
        end
      end
    end
  end

  // Single state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // Bus answers: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;

  // Clock enables and oscillator controls
  assign pllDrive.powerOn = s.pllEn;
  assign pllDrive.refTick = s.refTick;
  assign pllDrive.fbTick = s.fbTick;
  assign cpuClkEn = s.cpuTick;
  assign usbClkEn = s.usbTick;
  assign periphClkEn = s.pTick;
  assign cpuRun = (s.mode == PM_RUN) && execOk;
  // RC output gated in sleep, but still powered for quick wake
  assign rcOutEn = (s.mode == PM_RUN) || (s.mode == PM_IDLE) || (s.mode == PM_HOLD);
  assign rcPowerOn = (s.mode != PM_PDOWN) && (s.mode != PM_DEEP);
  assign mainOscOn = s.mainOn;
  assign coreSupplyOn = (s.mode != PM_DEEP);
  assign chipResetReq = s.rstReq;

endmodule

/* File: core/clk_pwr_ctrl_consts.svh */
`ifndef CLK_PWR_CTRL_CONSTS_SVH
`define CLK_PWR_CTRL_CONSTS_SVH

// Register byte offsets
`define OFS_CLK_SRC 8'h00
`define OFS_PLL_CFG 8'h04
`define OFS_PLL_CTL 8'h08
`define OFS_PLL_STAT 8'h0C
`define OFS_CLK_DIV 8'h10
`define OFS_PERIPH_GATE 8'h14
`define OFS_PERIPH_DIV 8'h18
`define OFS_PWR_MODE 8'h1C

// Field positions
`define POS_PRE_DIV 0
`define POS_MULT 8
`define POS_PLL_EN 0
`define POS_PLL_CONN 1
`define POS_PLL_LOCK 2
`define POS_CPU_DIV 0
`define POS_USB_DIV 8
`define POS_MAIN_READY 4

// Reset values
`define RST_PRE_DIV 8'h00
`define RST_MULT 15'h0000
`define RST_DIV 8'h00
`define RST_GATE 4'hF

// Power mode command codes
`define CMD_IDLE 3'h1
`define CMD_SLEEP 3'h2
`define CMD_PDOWN 3'h3
`define CMD_DEEP 3'h4

// Timing
`define CLK_MHZ 125
`define RC_START_US 60
`define HOLD_RC_TICKS 13'h0004
`define HOLD_MAIN_TICKS 13'h1000

`endif

/* File: core/clk_pwr_ctrl_pkg.sv */
package clk_pwr_ctrl_pkg;

  typedef enum logic [1:0] {
    SRC_RC = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_RTC = 2'b10
  } clk_src_e;

  typedef enum logic [2:0] {
    PM_RUN = 3'b000,
    PM_IDLE = 3'b001,
    PM_SLEEP = 3'b010,
    PM_PDOWN = 3'b011,
    PM_DEEP = 3'b100,
    PM_RCSTART = 3'b101,
    PM_HOLD = 3'b110
  } pwr_mode_e;

  // One-cycle tick pulses from the oscillators and the PLL core
  typedef struct packed {
    logic rc;
    logic main;
    logic rtc;
    logic currentControlledOscillator;
  } osc_ticks_s;

  // Controls toward the analog PLL core
  typedef struct packed {
    logic powerOn;
    logic refTick;
    logic fbTick;
  } pll_drive_s;

endpackage

/* File: verification/clock_and_power_mode_control_properties.sv */
`timescale 1ns/1ps
module clock_and_power_mode_control_properties
  import clk_pwr_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic wakeIrq,
  input wire pll_drive_s pllDrive,
  input wire logic cpuClkEn,
  input wire logic usbClkEn,
  input wire logic [3:0] periphClkEn,
  input wire logic cpuRun,
  input wire logic rcOutEn,
  input wire logic rcPowerOn,
  input wire logic coreSupplyOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Sleep and RC start-up are the two gated modes that keep the RC powered
  sequence asleep;
    !rcOutEn && rcPowerOn;
  endsequence
  sequence wokeSleep;
    asleep ##0 wakeIrq;
  endsequence
  a_bus_always_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
  a_pll_reset_off: assert property ($rose(rst_n) |-> !pllDrive.powerOn)
    else $error("pll on after reset");
  // Two cycles, since enables are registered one cycle behind the mode
  a_gated_quiet: assert property ((!rcOutEn)[*2] |-> !cpuClkEn && !usbClkEn &&
    periphClkEn == 4'h0) else $error("clock pulse while gated");
  a_sleep_pll_off: assert property (asleep [*2] |-> !pllDrive.powerOn)
    else $error("pll on in sleep");
  a_rc_off_gated: assert property (!rcPowerOn |-> !rcOutEn && !cpuRun)
    else $error("rc output while unpowered");
  a_deep_all_off: assert property (!coreSupplyOn |-> !rcPowerOn && !cpuRun)
    else $error("activity without core supply");
  a_run_clocked: assert property (cpuRun |-> rcOutEn) else $error("run while gated");
  a_idle_cpu_stop: assert property ((!cpuRun)[*2] |-> !cpuClkEn)
    else $error("cpu clock while halted");
  a_sleep_wake: assert property (wokeSleep |-> ##[1:16] cpuRun)
    else $error("late sleep wake");
endmodule

/* File: verification/tb_clock_and_power_mode_control.sv */
`timescale 1ns/1ps
`include "clk_pwr_ctrl_consts.svh"
module tb_clock_and_power_mode_control;
  import clk_pwr_ctrl_pkg::*;
  localparam int RCS = 20;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, pllLock, wakeIrq;
  logic cpuClkEn, usbClkEn, cpuRun, rcOutEn, rcPowerOn, mainOscOn, coreSupplyOn, chipResetReq;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans, ph;
  logic [2:0] hsize;
  logic [3:0] periphClkEn;
  osc_ticks_s ticks;
  pll_drive_s pllDrive;
  int fails, compares, cyc, cpuN, refN, n, fbN, usbN, rstN;
  int perN [4];

  clock_and_power_mode_control #(.RC_START_CYC(RCS)) i_dut (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ticks(ticks), .pllLock(pllLock), .wakeIrq(wakeIrq),
    .pllDrive(pllDrive), .cpuClkEn(cpuClkEn), .usbClkEn(usbClkEn),
    .periphClkEn(periphClkEn), .cpuRun(cpuRun), .rcOutEn(rcOutEn), .rcPowerOn(rcPowerOn),
    .mainOscOn(mainOscOn), .coreSupplyOn(coreSupplyOn), .chipResetReq(chipResetReq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // RC and main tick every other cycle, rtc every fourth, PLL oscillator every cycle
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    ticks <= '{rc: ph[0], main: ph[0], rtc: ph == 2'h0, currentControlledOscillator: 1'b1};
    cyc <= cyc + 1;
    // Reset request is a one-cycle pulse, so count it here
    if (chipResetReq === 1'b1) begin
      rstN <= rstN + 1;
    end
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single transfer; read data taken at the edge ending the data phase
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rv, exp);
  endtask

  task count(input int k);
    cpuN = 0;
    refN = 0;
    fbN = 0;
    usbN = 0;
    perN = '{0, 0, 0, 0};
    repeat (k) begin
      @(posedge clk);
      #1;
      cpuN += cpuClkEn;
      refN += pllDrive.refTick;
      fbN += pllDrive.fbTick;
      usbN += usbClkEn;
      foreach (perN[i]) perN[i] += periphClkEn[i];
    end
  endtask

  // One-cycle wake pulse, then cycles until execution resumes
  task wake;
    @(posedge clk);
    wakeIrq <= 1'b1;
    @(posedge clk);
    wakeIrq <= 1'b0;
    n = 0;
    while (cpuRun !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
  endtask

  task results;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    {rst_n, hsel, hwrite, pllLock, wakeIrq, ph, htrans} = '0;
    {haddr, hwdata, ticks, fails, compares, cyc} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk(cpuRun, 32'h1);
    rdc(`OFS_CLK_SRC, 32'h0);
    rdc(`OFS_PLL_STAT, 32'h0);
    rdc(`OFS_PERIPH_GATE, 32'hF);
    xfer(1'b1, `OFS_CLK_SRC, 32'h1);
    #1;
    chk(cpuRun, 32'h0);
    while (cpuRun !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    chk(n > 8000, 32'h1);
    rdc(`OFS_PLL_STAT, 32'h10);
    $display("reset and wake-up timer done");
    for (int s = 2; s >= 0; s--) begin
      xfer(1'b1, `OFS_CLK_SRC, s);
      rdc(`OFS_CLK_SRC, s);
    end
    xfer(1'b1, `OFS_CLK_SRC, 32'h3);
    rdc(`OFS_CLK_SRC, 32'h0);
    xfer(1'b1, `OFS_PLL_CFG, 32'h007FFFFF);
    rdc(`OFS_PLL_CFG, 32'h007FFFFF);
    xfer(1'b1, `OFS_PLL_CFG, 32'h00000703);
    xfer(1'b1, `OFS_PLL_CTL, 32'h2);
    rdc(`OFS_PLL_STAT, 32'h10);
    xfer(1'b1, `OFS_PLL_CTL, 32'h3);
    pllLock <= 1'b1;
    count(64);
    chk(refN inside {[7:9]}, 32'h1);
    chk(cpuN inside {[60:64]}, 32'h1);
    chk(fbN inside {[7:9]}, 32'h1);
    chk(usbN inside {[60:64]}, 32'h1);
    rdc(`OFS_PLL_STAT, 32'h17);
    xfer(1'b1, `OFS_PERIPH_DIV, 32'h00000300);
    xfer(1'b1, `OFS_PERIPH_GATE, 32'hB);
    count(64);
    chk(perN[2], 32'h0);
    chk(perN[0] > perN[1], 32'h1);
    $display("source and pll done");
    xfer(1'b1, `OFS_PWR_MODE, 32'h1);
    count(16);
    chk(cpuN, 32'h0);
    chk(perN[0] > 0, 32'h1);
    wake();
    chk(n < 3, 32'h1);
    xfer(1'b1, `OFS_CLK_DIV, 32'h0201);
    xfer(1'b1, `OFS_PWR_MODE, 32'h2);
    rdc(`OFS_PWR_MODE, 32'h2);
    count(16);
    chk(cpuN + perN[0] + perN[3], 32'h0);
    chk(usbN, 32'h0);
    chk(mainOscOn, 32'h0);
    wake();
    chk(n inside {[4:16]}, 32'h1);
    rdc(`OFS_CLK_DIV, 32'h0);
    rdc(`OFS_PLL_STAT, 32'h4);
    xfer(1'b1, `OFS_CLK_DIV, 32'h0201);
    $display("idle and sleep done");
    xfer(1'b1, `OFS_CLK_SRC, 32'h2);
    xfer(1'b1, `OFS_PWR_MODE, 32'h3);
    #1;
    chk(rcPowerOn, 32'h0);
    wake();
    chk(n >= RCS, 32'h1);
    rdc(`OFS_CLK_SRC, 32'h0);
    xfer(1'b1, `OFS_PLL_CFG, 32'h5);
    xfer(1'b1, `OFS_PWR_MODE, 32'h4);
    #1;
    chk(coreSupplyOn, 32'h0);
    wake();
    rdc(`OFS_PLL_CFG, 32'h0);
    rdc(`OFS_PERIPH_GATE, 32'hF);
    chk(rstN, 32'h1);
    $display("power-down and deep done");
    results();
  end
endmodule

bind clock_and_power_mode_control clock_and_power_mode_control_properties i_props (
  .clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp), .wakeIrq(wakeIrq),
  .pllDrive(pllDrive), .cpuClkEn(cpuClkEn), .usbClkEn(usbClkEn), .periphClkEn(periphClkEn),
  .cpuRun(cpuRun), .rcOutEn(rcOutEn), .rcPowerOn(rcPowerOn), .coreSupplyOn(coreSupplyOn));
